//--- rtl/sram_host_ctrl.sv
/*
 the file holds the host side controller of a 128k by 16 asynchronous static ram with two
 byte lanes. it assumes the memory pins are wired straight to the ports, and the
 testbench resolves the data bus from data_oe_out.
*/
// Behaviour
// [R1] chip select high floats data and ignores other strobes
// [R2] both lanes high deselect the memory
// [R3] select and output drive low with write high reads the word
// [R4] low lane alone reads bits 0 to 7
// [R5] upper lane alone reads bits 8 to 15
// [R6] select and write low with both lanes writes sixteen bits
// [R7] low lane alone writes only bits 0 to 7
// [R8] upper lane alone writes only bits 8 to 15
// [R9] write begins when last of strobe, select, lane goes active
// [R10] write ends as soon as any of them goes inactive
// [R11] host holds write data around the terminating edge
// [R12] host keeps write strobe high through every read
// [R13] address-led reads keep select, output drive and lanes low
// [R14] host sets address before select and lanes go low; here lanes go low in the same cycle as the address
// [R15] select rising with write rising keeps outputs floating
// [R16] host never drives the bus while memory drives it
// [R17] write pulse with output drive low covers setup plus float time
// [R18] host keeps lane enables steady while chip is enabled
// [R19] array is 131072 words of sixteen bits, 17-bit address
// [R20] access runs address setup, timed strobe, release and hold
`timescale 1ns/1ns
module sram_host_ctrl
  import sram_host_pkg::*;
#(
  parameter int AW = ADDR_W, // address width
  parameter int DW = DATA_W, // data width
  parameter int STROBE_CYC = WRITE_PULSE_CYC // write strobe timer count, strobe lasts one cycle more
) (
  input wire logic sys_clk_in, // system clock
  input wire logic resetn_in, // async reset, low
  input wire logic req_valid_in, // access request
  input wire logic req_write_in, // 1 write, 0 read
  input wire logic [AW-1:0] req_addr_in, // word address
  input wire logic [DW-1:0] req_wdata_in, // write data
  input wire logic [LANE_W-1:0] req_lanes_in, // bit1 upper, bit0 low
  output logic req_ready_out, // controller idle
  output logic rd_valid_out, // read data pulse
  output logic [DW-1:0] rd_data_out, // read data
  output logic [AW-1:0] mem_addr_out, // address pins
  output logic chip_select_n_out, // chip select, low
  output logic write_strobe_n_out, // write strobe, low
  output logic output_drive_n_out, // output drive, low
  output logic upper_byte_lane_n_out, // upper lane, low
  output logic low_byte_lane_n_out, // low lane, low
  output logic [DW-1:0] data_out, // data pins, out
  output logic [DW-1:0] data_oe_out, // data drive enable
  input wire logic [DW-1:0] data_in // data pins, in
);
  localparam int HB = DW / 2; // one byte lane

  // whole controller state, registered as one word
  typedef struct packed {
    seq_state_t state;
    logic write;
    logic [LANE_W-1:0] lanes;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic rd_valid;
    logic cs_n;
    logic we_n;
    logic oe_n;
    logic ready;
    logic ub_n;
    logic lb_n;
    logic [DW-1:0] doe;
    logic [DW-1:0] sync1;
    logic [DW-1:0] sync2;
  } ctrl_t;
  ctrl_t st_r;
  ctrl_t st_nxt;

  // handshake to the phase timer
  sram_seq_if seq ();
  logic [CNT_W-1:0] load_cnt;
  logic load;

  // one shared timer, since only one phase runs at a time
  sram_cycle_timer u_timer (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .seq(seq)
  );
  // sequencer drives the timer through the interface
  assign seq.load = load;
  assign seq.count = load_cnt;

  // per-lane drive enable, write data only on lanes being written
  function automatic logic [DW-1:0] lane_mask(input logic [LANE_W-1:0] lanes);
    lane_mask = {{HB{lanes[1]}}, {HB{lanes[0]}}};
  endfunction : lane_mask

  // [R20] setup, timed strobe, hold
  // sequencer: setup, strobe, hold, then turnaround before next access
  // defaults hold every field except rd_valid, ready and the synchroniser stages, so a phase changes only what it names
  always_comb begin
    st_nxt = st_r;
    load = 1'b0;
    load_cnt = '0;
    st_nxt.rd_valid = 1'b0;
    // synchroniser: first stage feeds only the second
    st_nxt.sync1 = data_in;
    st_nxt.sync2 = st_r.sync1;

    unique case (st_r.state)
      ST_IDLE: begin
        // an empty lane set would deselect the memory, so it is refused
        if (req_valid_in && req_lanes_in != LANES_OFF) begin
          // [R14] address before select
          st_nxt.addr = req_addr_in;
          st_nxt.write = req_write_in;
          st_nxt.lanes = req_lanes_in;
          // [R18] lane pins move only while deselected
          st_nxt.ub_n = ~req_lanes_in[1];
          st_nxt.lb_n = ~req_lanes_in[0];
          st_nxt.wdata = req_wdata_in;
          st_nxt.state = ST_SETUP;
          load = 1'b1;
          load_cnt = CNT_W'(ADDR_SETUP_CYC);
        end
      end

      ST_SETUP: begin
        if (seq.done) begin
          // [R9] select and strobe together, lanes already low two cycles earlier
          st_nxt.cs_n = 1'b0;
          st_nxt.state = ST_STROBE;
          load = 1'b1;
          if (st_r.write) begin
            // [R17] output drive stays high, no float time needed
            // [R6] strobe low, output drive held high
            st_nxt.we_n = 1'b0;
            // [R16] drive only while output drive is off
            st_nxt.doe = lane_mask(st_r.lanes);
            load_cnt = CNT_W'(STROBE_CYC);
          end else begin
            // [R13] select and drive held whole read
            // [R12] write strobe stays high
            st_nxt.oe_n = 1'b0;
            load_cnt = CNT_W'(READ_ACCESS_CYC);
          end
        end
      end

      ST_STROBE: begin
        if (seq.done) begin
          // [R10] strobe and select end together
          st_nxt.we_n = 1'b1;
          st_nxt.cs_n = 1'b1;
          st_nxt.oe_n = 1'b1;
          st_nxt.state = ST_HOLD;
          if (!st_r.write) begin
            // [R4] [R5] only enabled lanes are kept
            st_nxt.rdata = st_r.sync2 & lane_mask(st_r.lanes);
            st_nxt.rd_valid = 1'b1;
          end
        end
      end

      ST_HOLD: begin
        // [R11] data held one cycle past the terminating edge
        st_nxt.doe = '0;
        st_nxt.state = ST_TURN;
        load = 1'b1;
        load_cnt = CNT_W'(TURNAROUND_CYC);
      end

      ST_TURN: begin
        // [R15] lets the memory float before the next access
        if (seq.done) begin
          st_nxt.state = ST_IDLE;
        end
      end
    endcase

    // ready is registered so the handshake pin comes from a flip-flop
    st_nxt.ready = (st_nxt.state == ST_IDLE);
  end

  // one register word; the async reset loads constants only
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // every strobe and lane pin resets high, the controller idles ready
      st_r <= '{
        state: ST_IDLE,
        ready: 1'b1,
        cs_n: 1'b1,
        we_n: 1'b1,
        oe_n: 1'b1,
        ub_n: 1'b1,
        lb_n: 1'b1,
        default: '0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  // request side, all straight from flip-flops
  assign req_ready_out = st_r.ready;
  assign rd_valid_out = st_r.rd_valid;
  assign rd_data_out = st_r.rdata;

  // memory control pins
  assign mem_addr_out = st_r.addr;
  assign chip_select_n_out = st_r.cs_n;
  assign write_strobe_n_out = st_r.we_n;
  assign output_drive_n_out = st_r.oe_n;

  // [R18] lanes change only while select is high, steady otherwise
  assign upper_byte_lane_n_out = st_r.ub_n;
  assign low_byte_lane_n_out = st_r.lb_n;

  // data bus pins, drive enable per bit
  assign data_out = st_r.wdata;
  assign data_oe_out = st_r.doe;
endmodule : sram_host_ctrl

//--- rtl/sram_host_pkg.sv
/*
 the package holds the widths, pin timing constants and state names of the asynchronous
 static ram host controller. it assumes a 125 MHz system clock.
*/
package sram_host_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int LANE_W = 2;
  localparam int CLK_PERIOD_NS = 8;
  // timing figures of the memory, in ns
  localparam int ADDR_SETUP_NS = 0;
  localparam int WRITE_PULSE_NS = 35;
  localparam int DATA_SETUP_NS = 25;
  localparam int WRITE_TO_FLOAT_NS = 18;
  localparam int READ_ACCESS_NS = 45;
  localparam int TURNAROUND_NS = 18;
  // least times round up to whole cycles, address setup never below one
  localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
    (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // pulse with output drive low must cover data setup plus float time
  localparam int WE_OE_LOW_CYC = (DATA_SETUP_NS + WRITE_TO_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // two extra cycles for the input synchroniser on the data pins
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  localparam int TURNAROUND_CYC = (TURNAROUND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [LANE_W-1:0] LANES_OFF = 2'h0;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_TURN
  } seq_state_t;
endpackage : sram_host_pkg

//--- rtl/sram_seq_if.sv
/*
 the interface carries the timing handshake between the pin sequencer and its cycle timer.
 it assumes both ends sit on the same clock.
*/
`timescale 1ns/1ns
interface sram_seq_if;
  import sram_host_pkg::*;
  logic load;
  logic [CNT_W-1:0] count;
  logic done;
  modport ctrl (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface : sram_seq_if

//--- rtl/sram_cycle_timer.sv
/*
 the file holds the phase timer that counts down one phase of a memory access.
 it assumes the loader holds a count of at least one.
*/
`timescale 1ns/1ns
module sram_cycle_timer
  import sram_host_pkg::*;
(
  input wire logic sys_clk_in, // system clock
  input wire logic resetn_in, // async reset, low
  sram_seq_if.timer seq // load and done
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic done;
  } timer_t;
  timer_t st_r;
  timer_t st_nxt;
  // done pulses in the cycle the count reaches zero
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (seq.load) begin
      st_nxt.cnt = seq.count;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
      st_nxt.done = (st_r.cnt == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign seq.done = st_r.done;
endmodule : sram_cycle_timer

//--- tb/sram_host_chk.sv
/* pin sequencing checker of the ram host controller.
 assumes the default strobe count of five, which holds the strobe six cycles */
`timescale 1ns/1ns
module sram_host_chk #(parameter int AW = 17, parameter int DW = 16) (
  input wire logic sys_clk_in, // clock
  input wire logic resetn_in, // reset, low
  input wire logic req_ready_out, // idle
  input wire logic rd_valid_out, // read pulse
  input wire logic [AW-1:0] mem_addr_out, // address
  input wire logic chip_select_n_out, // select
  input wire logic write_strobe_n_out, // write
  input wire logic output_drive_n_out, // drive
  input wire logic upper_byte_lane_n_out, // upper
  input wire logic low_byte_lane_n_out, // low
  input wire logic [DW-1:0] data_out, // data
  input wire logic [DW-1:0] data_oe_out // enable
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  // end of a read or write phase
  sequence rd_end; $rose(chip_select_n_out) && !$past(output_drive_n_out); endsequence
  sequence wr_end; $rose(write_strobe_n_out); endsequence
  // data still driven at the terminating edge, released one cycle later
  sequence wr_release; $stable(data_out) && data_oe_out != '0 ##1 data_oe_out == '0; endsequence
  // lanes move at the take, select follows two cycles on
  sequence lane_move; $changed({upper_byte_lane_n_out, low_byte_lane_n_out}) && chip_select_n_out; endsequence
  // strobe low six cycles, then hold and turnaround keep ready low five cycles
  sequence wr_start; $fell(write_strobe_n_out); endsequence
  sequence wr_pulse; !write_strobe_n_out [*6] ##1 write_strobe_n_out; endsequence
  sequence wr_tail; !req_ready_out [*5] ##1 req_ready_out; endsequence
  a_we_high_read: assert property (!output_drive_n_out |-> write_strobe_n_out) else $error("write low in read");
  a_read_ends_together: assert property (rd_end |-> output_drive_n_out && rd_valid_out) else $error("read end split");
  a_addr_before_sel: assert property ($fell(chip_select_n_out) |-> $stable(mem_addr_out)) else $error("addr late");
  a_data_held_end: assert property (wr_end |-> wr_release) else $error("data hold");
  a_no_bus_fight: assert property (!output_drive_n_out |-> data_oe_out == '0) else $error("bus contention");
  a_write_drive_off: assert property (!write_strobe_n_out |-> output_drive_n_out) else $error("drive low in write");
  a_lanes_then_sel: assert property (lane_move |-> ##2 !chip_select_n_out) else $error("lane toggle idle");
  a_strobe_then_hold: assert property (wr_start |-> wr_pulse ##0 wr_tail) else $error("strobe timing");
endmodule : sram_host_chk

//--- tb/sram_dev_model.sv
/* behavioural model of the byte lane static ram.
 assumes the bench resolves the data bus from both enables */
`timescale 1ns/1ns
module sram_dev_model #(parameter int DLY = 20) (
  input wire logic [16:0] addr_in, // address
  input wire logic cs_n_in, // select
  input wire logic we_n_in, // write
  input wire logic oe_n_in, // drive
  input wire logic ub_n_in, // upper lane
  input wire logic lb_n_in, // low lane
  input wire logic [15:0] dq_in, // bus
  output logic [15:0] dq_out, // read data
  output logic [15:0] dq_oe_out // per bit drive
);
  logic [15:0] mem [0:131071];
  // standby unless selected with a lane
  wire sel = !cs_n_in && !(ub_n_in && lb_n_in);
  wire wr = sel && !we_n_in;
  always @* begin
    if (wr && !lb_n_in) mem[addr_in][7:0] = dq_in[7:0];
    if (wr && !ub_n_in) mem[addr_in][15:8] = dq_in[15:8];
  end
  // slow answer, floats at once on deselect
  assign #DLY dq_out = mem[addr_in];
  assign dq_oe_out = (sel && we_n_in && !oe_n_in) ? {{8{!ub_n_in}}, {8{!lb_n_in}}} : 16'h0;
endmodule : sram_dev_model

//--- tb/tb.sv
/* self checking bench of the ram host controller.
 assumes default strobe, read and turnaround counts */
`timescale 1ns/1ns
module tb;
  logic sys_clk_in = 1'h0, resetn_in = 1'h0, req_valid = 1'h0, req_write = 1'h0;
  logic [16:0] req_addr = 17'h0;
  logic [15:0] req_wdata = 16'h0, flt = 16'h00ff;
  logic [1:0] req_lanes = 2'h0;
  wire ready, rd_valid, cs_n, we_n, oe_n, ub_n, lb_n;
  wire [16:0] addr;
  wire [15:0] rd_data, h_d, h_oe, m_d, m_oe;
  // undriven bits show a pattern that flips each cycle
  wire [15:0] bus = (h_oe & h_d) | (m_oe & m_d) | (~(h_oe | m_oe) & flt);
  int miscompares = 0, checks_done = 0;
  sram_host_ctrl i_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .req_valid_in(req_valid),
    .req_write_in(req_write), .req_addr_in(req_addr), .req_wdata_in(req_wdata), .req_lanes_in(req_lanes),
    .req_ready_out(ready), .rd_valid_out(rd_valid), .rd_data_out(rd_data), .mem_addr_out(addr),
    .chip_select_n_out(cs_n), .write_strobe_n_out(we_n), .output_drive_n_out(oe_n),
    .upper_byte_lane_n_out(ub_n), .low_byte_lane_n_out(lb_n), .data_out(h_d), .data_oe_out(h_oe), .data_in(bus));
  sram_dev_model i_mem (.addr_in(addr), .cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(oe_n), .ub_n_in(ub_n),
    .lb_n_in(lb_n), .dq_in(bus), .dq_out(m_d), .dq_oe_out(m_oe));
  // clock and float pattern
  initial forever #4 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) flt <= ~flt;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one access, entered and left 1 ns after an edge so outputs are settled when looked at
  task automatic acc(input logic w, input logic [16:0] a, input logic [15:0] d, input logic [1:0] ln);
    int n;
    n = 0;
    {req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'h1, w, a, d, ln};
    while (ready !== 1'h1) begin
      @(posedge sys_clk_in);
      #1;
    end
    // ready stands high here, so the next edge takes the request
    @(posedge sys_clk_in);
    #1 req_valid = 1'h0;
    do begin
      @(posedge sys_clk_in);
      #1 n++;
    end while (n < 200 && (w ? ready !== 1'h1 : rd_valid !== 1'h1));
    chk("access end", 16'h0, (n >= 200) ? 16'h1 : 16'h0);
  endtask : acc
  task automatic t_word();
    acc(1'h1, 17'h0, 16'hbeef, 2'h3);
    acc(1'h0, 17'h0, 16'h0, 2'h3);
    chk("word read", 16'hbeef, rd_data);
    $display("test word done");
  endtask : t_word
  task automatic t_lanes();
    acc(1'h1, 17'h1ffff, 16'hbeef, 2'h3);
    acc(1'h1, 17'h1ffff, 16'h1234, 2'h1);
    acc(1'h1, 17'h1ffff, 16'h5600, 2'h2);
    acc(1'h0, 17'h1ffff, 16'h0, 2'h3);
    chk("lane merge", 16'h5634, rd_data);
    acc(1'h0, 17'h1ffff, 16'h0, 2'h1);
    chk("low lane read", 16'h0034, rd_data);
    acc(1'h0, 17'h1ffff, 16'h0, 2'h2);
    chk("upper lane read", 16'h5600, rd_data);
    $display("test lanes done");
  endtask : t_lanes
  task automatic t_refuse();
    logic seen;
    seen = 1'h0;
    {req_valid, req_write, req_lanes} = {1'h1, 1'h1, 2'h0};
    repeat (12) begin
      @(posedge sys_clk_in);
      #1 seen = seen | !cs_n | !we_n;
    end
    req_valid = 1'h0;
    chk("no lane no access", 16'h0, {15'h0, seen});
    $display("test refuse done");
  endtask : t_refuse
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk_in);
    #1 resetn_in = 1'h1;
    t_word();
    t_lanes();
    t_refuse();
    end_sim();
  end
  // watchdog
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
endmodule : tb
bind sram_host_ctrl sram_host_chk #(.AW(AW), .DW(DW)) i_chk (.*);
